// >>> core/mito_cfg.svh
// How it works
// - options frozen once captured after reset
// - option picks watchdog clock, another enables it
// - option picks single or paired watchdog clear
// - option picks crystal or rc oscillator mode
// - options enable pull-highs and pwm outputs
// - each port a pin has wake enable
// - option picks divider pin: io or tone
// - option enables low voltage reset
// - instruction cycle is four clocks
// - jumps, calls, returns, table reads: two cycles
// - pc low byte write jumps, extra cycle
// - taken skip costs one extra cycle
// - skip tests memory byte or bit
// - call saves return point, return resumes after
// - add carries above 255, subtract borrows below 0
// - increment and decrement change by exactly one
// - logic results set zero flag when zero
// - rotates move one bit, carry variants via carry
// - bit set and clear touch only that bit
// - transfers: mem to acc, acc to mem, immediate
// - table read delivers program memory data to acc
// - disabled watchdog makes its instructions no-ops
`ifndef MITO_CFG_SVH
`define MITO_CFG_SVH
`define MITO_PC_W 12
`define MITO_PC_STEP 12'h001
`define MITO_PC_SKIP 12'h002
`define MITO_PH_LAST 2'h3
`define MITO_PH_STEP 2'h1
`define MITO_ACC_RST 8'h00
`define MITO_PC_RST 12'h000
`define MITO_CFG_RST 20'h00000
`define MITO_BYTE_ONE 8'h01
`endif

// >>> core/mito_pkg.sv
`include "mito_cfg.svh"
`default_nettype none
package mito_pkg;
    // operation classes delivered by the decoder
    typedef enum logic [4:0] {
        OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_CPL,
        OP_INC, OP_DEC, OP_RR, OP_RL, OP_RRC, OP_RLC, OP_BSET, OP_BCLR,
        OP_MOV_MA, OP_MOV_AM, OP_MOV_IA, OP_JMP, OP_CALL, OP_RET, OP_INTERRUPT_EXIT,
        OP_TBL, OP_SKZ, OP_SKBIT, OP_WDC, OP_WDC1, OP_WDC2
    } mito_op_t;
    // one decoded instruction
    typedef struct packed {
        mito_op_t op;
        logic src_imm;
        logic to_mem;
        logic to_pcl;
        logic [2:0] bit_idx;
        logic [7:0] imm;
        logic [`MITO_PC_W-1:0] target;
    } mito_instr_t;
    // programmed options
    typedef struct packed {
        logic wdt_from_osc;
        logic wdt_en;
        logic wdt_dual_clear;
        logic osc_rc;
        logic [3:0] pull_en;
        logic [1:0] pwm_en;
        logic [7:0] wake_en;
        logic tone_div_out;
        logic lvr_en;
    } mito_cfg_t;
    typedef enum logic {ST_EXEC, ST_EXTRA} mito_state_t;
endpackage : mito_pkg
`default_nettype wire

// >>> core/mito_core.sv
`include "mito_cfg.svh"
`default_nettype none
module mito_core #(
    parameter int STACK_D = 4,
    parameter int WDT_W = 16
) (
    input wire logic clk_i, // system clock
    input wire logic arst_n_i, // async reset, low
    input wire mito_pkg::mito_cfg_t cfg_i, // fuse options
    input wire logic wdt_osc_i, // dedicated watchdog oscillator pin
    input wire logic instr_valid_i, // decoded instruction present
    input wire mito_pkg::mito_instr_t instr_i, // decoded instruction
    input wire logic [7:0] mem_rdata_i, // addressed data memory byte
    input wire logic [7:0] table_data_i, // program memory table byte
    output logic instr_ready_o, // instruction can be taken this clock
    output logic retire_o, // instruction completed pulse
    output logic [`MITO_PC_W-1:0] pc_o, // program counter
    output logic [7:0] acc_o, // accumulator
    output logic carry_o, // carry flag
    output logic zero_o, // zero flag
    output logic mem_we_o, // data memory write pulse
    output logic [7:0] mem_wdata_o, // data memory write byte
    output logic [`MITO_PC_W-1:0] tbl_addr_o, // table address
    output logic wdt_timeout_o, // watchdog overflow pulse
    output mito_pkg::mito_cfg_t cfg_o // frozen options
);
    localparam int SPW = $clog2(STACK_D);

    // ****************************************
    // option capture
    // ****************************************
    mito_pkg::mito_cfg_t cfg_reg, cfg_next; // held options
    logic cfg_loaded_reg, cfg_loaded_next; // capture done

    // options are caught once after reset, then nothing can alter them
    always_comb
    begin
        cfg_loaded_next = 1'b1;
        cfg_next = cfg_loaded_reg ? cfg_reg : cfg_i;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cfg_reg <= `MITO_CFG_RST;
            cfg_loaded_reg <= 1'b0;
        end
        else
        begin
            cfg_reg <= cfg_next;
            cfg_loaded_reg <= cfg_loaded_next;
        end
    end
    // osc mode, pull-highs, pwm, wake mask, tone pin, lvr go straight out
    assign cfg_o = cfg_reg;

    // ****************************************
    // instruction cycle sequencer
    // ****************************************
    mito_pkg::mito_state_t state_reg, state_next; // exec or extra cycle
    logic [1:0] phase_reg, phase_next; // clock within cycle
    logic retire_reg, retire_next; // completion pulse
    logic accept; // instruction taken now
    logic extra; // taken instruction needs a second cycle
    logic last_ph; // final clock of an instruction cycle

    assign last_ph = (phase_reg == `MITO_PH_LAST);
    assign instr_ready_o = (state_reg == mito_pkg::ST_EXEC) && last_ph;
    assign accept = instr_ready_o && instr_valid_i;

    // four clocks make one instruction cycle
    always_comb
    begin
        phase_next = phase_reg + `MITO_PH_STEP;
        state_next = state_reg;
        retire_next = 1'b0;
        case (state_reg)
            mito_pkg::ST_EXEC:
            begin
                if (accept && extra)
                    state_next = mito_pkg::ST_EXTRA;
                else if (accept)
                    retire_next = 1'b1;
            end
            mito_pkg::ST_EXTRA:
            begin
                // dummy cycle ends the two-cycle instruction
                if (last_ph)
                begin
                    state_next = mito_pkg::ST_EXEC;
                    retire_next = 1'b1;
                end
            end
            default: state_next = mito_pkg::ST_EXEC;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_reg <= mito_pkg::ST_EXEC;
            phase_reg <= 2'h0;
            retire_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            retire_reg <= retire_next;
        end
    end
    assign retire_o = retire_reg;

    // ****************************************
    // data path, program counter and stack
    // ****************************************
    logic [7:0] acc_reg, acc_next; // accumulator
    logic carry_reg, carry_next; // carry flag
    logic zero_reg, zero_next; // zero flag
    logic [`MITO_PC_W-1:0] pc_reg, pc_next; // program counter
    logic [`MITO_PC_W-1:0] stack_reg [STACK_D]; // return points
    logic [`MITO_PC_W-1:0] stack_next [STACK_D];
    logic [SPW-1:0] sp_reg, sp_next; // next free slot
    logic mem_we_reg, mem_we_next; // write strobe
    logic [7:0] wdata_reg, wdata_next; // write data
    logic [`MITO_PC_W-1:0] tbl_reg, tbl_next; // table address
    logic tbl_pend_reg, tbl_pend_next; // table byte due at cycle end
    logic [7:0] opnd; // second operand
    logic [8:0] wide; // result with carry or borrow
    logic [7:0] res; // result byte
    logic [7:0] mask; // addressed bit
    logic wr_res, dst_mem, c_upd, z_upd; // result steering
    logic [`MITO_PC_W-1:0] pc_inc; // following address
    logic [`MITO_PC_W-1:0] stack_top; // most recent return point

    assign pc_inc = pc_reg + `MITO_PC_STEP;
    assign stack_top = stack_reg[sp_reg - SPW'(1)];

    // operation results; nothing is committed here
    always_comb
    begin
        opnd = instr_i.src_imm ? instr_i.imm : mem_rdata_i;
        mask = `MITO_BYTE_ONE << instr_i.bit_idx;
        wide = 9'h000;
        res = opnd;
        wr_res = 1'b1;
        dst_mem = instr_i.to_mem;
        c_upd = 1'b0;
        z_upd = 1'b1;
        case (instr_i.op)
            mito_pkg::OP_ADD:
            begin
                wide = {1'b0, acc_reg} + {1'b0, opnd};
                res = wide[7:0];
                c_upd = 1'b1;
            end
            mito_pkg::OP_SUB:
            begin
                wide = {1'b0, acc_reg} - {1'b0, opnd};
                res = wide[7:0];
                c_upd = 1'b1;
            end
            mito_pkg::OP_AND: res = acc_reg & opnd;
            mito_pkg::OP_OR: res = acc_reg | opnd;
            mito_pkg::OP_XOR: res = acc_reg ^ opnd;
            mito_pkg::OP_CPL: res = ~opnd;
            mito_pkg::OP_INC: res = opnd + `MITO_BYTE_ONE;
            mito_pkg::OP_DEC: res = opnd - `MITO_BYTE_ONE;
            mito_pkg::OP_RR: res = {opnd[0], opnd[7:1]};
            mito_pkg::OP_RL: res = {opnd[6:0], opnd[7]};
            mito_pkg::OP_RRC:
            begin
                res = {carry_reg, opnd[7:1]};
                wide[8] = opnd[0];
                c_upd = 1'b1;
            end
            mito_pkg::OP_RLC:
            begin
                res = {opnd[6:0], carry_reg};
                wide[8] = opnd[7];
                c_upd = 1'b1;
            end
            // read-modify-write of a single bit, others kept
            mito_pkg::OP_BSET:
            begin
                res = opnd | mask;
                dst_mem = 1'b1;
                z_upd = 1'b0;
            end
            mito_pkg::OP_BCLR:
            begin
                res = opnd & ~mask;
                dst_mem = 1'b1;
                z_upd = 1'b0;
            end
            // three transfer forms
            mito_pkg::OP_MOV_MA:
            begin
                dst_mem = 1'b0;
                z_upd = 1'b0;
            end
            mito_pkg::OP_MOV_AM:
            begin
                res = acc_reg;
                dst_mem = 1'b1;
                z_upd = 1'b0;
            end
            mito_pkg::OP_MOV_IA:
            begin
                res = instr_i.imm;
                dst_mem = 1'b0;
                z_upd = 1'b0;
            end
            default:
            begin
                wr_res = 1'b0; // no-op, table read, control flow and watchdog ops
                z_upd = 1'b0;
            end
        endcase
    end

    // commit results and steer the program counter
    always_comb
    begin
        acc_next = acc_reg;
        carry_next = carry_reg;
        zero_next = zero_reg;
        pc_next = pc_reg;
        stack_next = stack_reg;
        sp_next = sp_reg;
        mem_we_next = 1'b0;
        wdata_next = wdata_reg;
        tbl_next = tbl_reg;
        tbl_pend_next = tbl_pend_reg;
        extra = 1'b0;
        if (accept)
        begin
            pc_next = pc_inc;
            if (c_upd)
                carry_next = wide[8];
            if (z_upd)
                zero_next = (res == 8'h00);
            if (wr_res && instr_i.to_pcl)
            begin
                pc_next = {pc_reg[`MITO_PC_W-1:8], res};
                extra = 1'b1;
            end
            else if (wr_res && dst_mem)
            begin
                mem_we_next = 1'b1;
                wdata_next = res;
            end
            else if (wr_res)
                acc_next = res;
            case (instr_i.op)
                mito_pkg::OP_JMP:
                begin
                    pc_next = instr_i.target;
                    extra = 1'b1;
                end
                mito_pkg::OP_CALL:
                begin
                    stack_next[sp_reg] = pc_inc;
                    sp_next = sp_reg + SPW'(1);
                    pc_next = instr_i.target;
                    extra = 1'b1;
                end
                mito_pkg::OP_RET, mito_pkg::OP_INTERRUPT_EXIT:
                begin
                    pc_next = stack_top;
                    sp_next = sp_reg - SPW'(1);
                    extra = 1'b1;
                end
                mito_pkg::OP_TBL:
                begin
                    tbl_next = {pc_reg[`MITO_PC_W-1:8], acc_reg};
                    tbl_pend_next = 1'b1;
                    extra = 1'b1;
                end
                mito_pkg::OP_SKZ:
                begin
                    if (opnd == 8'h00)
                    begin
                        pc_next = pc_reg + `MITO_PC_SKIP;
                        extra = 1'b1;
                    end
                end
                mito_pkg::OP_SKBIT:
                begin
                    if ((opnd & mask) != 8'h00)
                    begin
                        pc_next = pc_reg + `MITO_PC_SKIP;
                        extra = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // table byte lands in the accumulator at the end of the dummy cycle
        if (state_reg == mito_pkg::ST_EXTRA && last_ph && tbl_pend_reg)
        begin
            acc_next = table_data_i;
            tbl_pend_next = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            acc_reg <= `MITO_ACC_RST;
            carry_reg <= 1'b0;
            zero_reg <= 1'b0;
            pc_reg <= `MITO_PC_RST;
            for (int i = 0; i < STACK_D; i++)
                stack_reg[i] <= `MITO_PC_RST;
            sp_reg <= '0;
            mem_we_reg <= 1'b0;
            wdata_reg <= 8'h00;
            tbl_reg <= `MITO_PC_RST;
            tbl_pend_reg <= 1'b0;
        end
        else
        begin
            acc_reg <= acc_next;
            carry_reg <= carry_next;
            zero_reg <= zero_next;
            pc_reg <= pc_next;
            stack_reg <= stack_next;
            sp_reg <= sp_next;
            mem_we_reg <= mem_we_next;
            wdata_reg <= wdata_next;
            tbl_reg <= tbl_next;
            tbl_pend_reg <= tbl_pend_next;
        end
    end
    assign pc_o = pc_reg;
    assign acc_o = acc_reg;
    assign carry_o = carry_reg;
    assign zero_o = zero_reg;
    assign mem_we_o = mem_we_reg;
    assign mem_wdata_o = wdata_reg;
    assign tbl_addr_o = tbl_reg;

    // ****************************************
    // watchdog
    // ****************************************
    logic [2:0] osc_sync_reg, osc_sync_next; // pin synchroniser
    logic osc_lvl_reg, osc_lvl_next; // settled oscillator level
    logic [WDT_W-1:0] wdt_reg, wdt_next; // watchdog counter
    logic half1_reg, half1_next, half2_reg, half2_next; // paired clear halves
    logic wto_reg, wto_next; // overflow pulse
    logic wd_tick, wd_clr; // count and clear events

    // osc edges count only after two later stages agree; ignores glitches
    always_comb
    begin
        osc_sync_next = {osc_sync_reg[1:0], wdt_osc_i};
        osc_lvl_next = (osc_sync_reg[1] == osc_sync_reg[2]) ? osc_sync_reg[2] : osc_lvl_reg;
        wd_tick = cfg_reg.wdt_from_osc ? (osc_lvl_next && !osc_lvl_reg) : last_ph;
        wd_clr = 1'b0;
        half1_next = half1_reg;
        half2_next = half2_reg;
        // with the option off every watchdog op falls through as a no-op
        if (accept && cfg_reg.wdt_en)
        begin
            case (instr_i.op)
                mito_pkg::OP_WDC: wd_clr = !cfg_reg.wdt_dual_clear;
                mito_pkg::OP_WDC1:
                begin
                    wd_clr = !cfg_reg.wdt_dual_clear || half2_reg;
                    half1_next = !wd_clr;
                    half2_next = 1'b0;
                end
                mito_pkg::OP_WDC2:
                begin
                    wd_clr = !cfg_reg.wdt_dual_clear || half1_reg;
                    half2_next = !wd_clr;
                    half1_next = 1'b0;
                end
                default: ;
            endcase
        end
        wto_next = cfg_reg.wdt_en && wd_tick && !wd_clr && (&wdt_reg);
        if (!cfg_reg.wdt_en || wd_clr)
            wdt_next = '0;
        else if (wd_tick)
            wdt_next = wdt_reg + WDT_W'(1);
        else
            wdt_next = wdt_reg;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            osc_sync_reg <= 3'h0;
            osc_lvl_reg <= 1'b0;
            wdt_reg <= '0;
            half1_reg <= 1'b0;
            half2_reg <= 1'b0;
            wto_reg <= 1'b0;
        end
        else
        begin
            osc_sync_reg <= osc_sync_next;
            osc_lvl_reg <= osc_lvl_next;
            wdt_reg <= wdt_next;
            half1_reg <= half1_next;
            half2_reg <= half2_next;
            wto_reg <= wto_next;
        end
    end
    assign wdt_timeout_o = wto_reg;

    // ****************************************
    // checks
    // ****************************************
    property p_cfg_frozen;
        @(posedge clk_i) disable iff (!arst_n_i) cfg_loaded_reg |=> $stable(cfg_o);
    endproperty
    a_cfg_frozen: assert property (p_cfg_frozen) else $error("options changed");
    property p_retire_gap;
        @(posedge clk_i) disable iff (!arst_n_i) retire_o |=> !retire_o [*3];
    endproperty
    a_retire_gap: assert property (p_retire_gap) else $error("cycle under 4 clocks");
    property p_jmp_two;
        @(posedge clk_i) disable iff (!arst_n_i)
            accept && instr_i.op == mito_pkg::OP_JMP |-> ##1 !retire_o [*4] ##1 retire_o;
    endproperty
    a_jmp_two: assert property (p_jmp_two) else $error("jump not two cycles");
    property p_pcl_jump;
        @(posedge clk_i) disable iff (!arst_n_i)
            accept && instr_i.op == mito_pkg::OP_MOV_AM && instr_i.to_pcl
            |=> pc_o[7:0] == $past(acc_o) ##4 retire_o;
    endproperty
    a_pcl_jump: assert property (p_pcl_jump) else $error("pc low write wrong");
    property p_skip;
        @(posedge clk_i) disable iff (!arst_n_i)
            accept && instr_i.op == mito_pkg::OP_SKZ && !instr_i.src_imm && mem_rdata_i == 8'h00
            |=> pc_o == $past(pc_o) + `MITO_PC_SKIP ##4 retire_o;
    endproperty
    a_skip: assert property (p_skip) else $error("skip wrong");
    property p_call_save;
        @(posedge clk_i) disable iff (!arst_n_i)
            accept && instr_i.op == mito_pkg::OP_CALL |=> stack_top == $past(pc_o) + `MITO_PC_STEP;
    endproperty
    a_call_save: assert property (p_call_save) else $error("return point lost");
    property p_add_carry;
        @(posedge clk_i) disable iff (!arst_n_i)
            accept && instr_i.op == mito_pkg::OP_ADD && !instr_i.to_pcl
            |=> carry_o == (({1'b0, $past(acc_o)} + {1'b0, $past(opnd)}) > 9'h0FF);
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("add carry wrong");
    property p_and_zero;
        @(posedge clk_i) disable iff (!arst_n_i)
            accept && instr_i.op == mito_pkg::OP_AND && !instr_i.to_pcl
            |=> zero_o == (($past(acc_o) & $past(opnd)) == 8'h00);
    endproperty
    a_and_zero: assert property (p_and_zero) else $error("zero flag wrong");
    property p_bit_set;
        @(posedge clk_i) disable iff (!arst_n_i)
            accept && instr_i.op == mito_pkg::OP_BSET && !instr_i.to_pcl
            |=> mem_we_o && mem_wdata_o == ($past(opnd) | $past(mask));
    endproperty
    a_bit_set: assert property (p_bit_set) else $error("bit set wrong");
    property p_wdt_off;
        @(posedge clk_i) disable iff (!arst_n_i) !cfg_o.wdt_en |=> !wdt_timeout_o && wdt_reg == '0;
    endproperty
    a_wdt_off: assert property (p_wdt_off) else $error("watchdog runs while off");
endmodule : mito_core
`default_nettype wire

// >>> tb/mito_core_bench.sv
`include "mito_cfg.svh"
`default_nettype none
// ****************************************
// self-checking bench: model beside the core
// ****************************************
module mito_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0; // system clock
    logic arst_n_i = 1'b0; // async reset, low
    mito_pkg::mito_cfg_t cfg_i = '0; // option fuses
    logic wdt_osc_i = 1'b0; // watchdog oscillator pin
    logic osc_run = 1'b0; // oscillator stands still while low
    logic instr_valid_i = 1'b0; // request strobe
    mito_pkg::mito_instr_t instr_i = '0; // decoded request
    logic [7:0] mem_rdata_i = 8'h00; // memory byte
    logic [7:0] table_data_i = 8'h00; // table byte
    logic instr_ready_o, retire_o, carry_o, zero_o, mem_we_o, wdt_timeout_o; // strobes, flags
    logic [`MITO_PC_W-1:0] pc_o, tbl_addr_o; // addresses
    logic [7:0] acc_o, mem_wdata_o; // data
    mito_pkg::mito_cfg_t cfg_o; // frozen options
    int acc, cy, zf, pc, failures, comparisons, to_cnt; // model state, counters
    int stk[$]; // model return stack
    always #20 clk_i = ~clk_i;
    // slow oscillator pin; it toggles on falling clock edges, away from sampling
    always #80 if (osc_run) wdt_osc_i = ~wdt_osc_i;
    // count overflow pulses on the falling edge, where the pulse has settled
    always @(negedge clk_i) if (wdt_timeout_o === 1'b1) to_cnt++;
    mito_core #(.STACK_D(4), .WDT_W(4)) i_dut (.clk_i, .arst_n_i, .cfg_i, .wdt_osc_i,
        .instr_valid_i, .instr_i, .mem_rdata_i, .table_data_i, .instr_ready_o, .retire_o,
        .pc_o, .acc_o, .carry_o, .zero_o, .mem_we_o, .mem_wdata_o, .tbl_addr_o,
        .wdt_timeout_o, .cfg_o);
    // ****************************************
    // helpers
    // ****************************************
    task automatic results;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // inputs other than the oscillator pin change 1 ns after the rising edge
    task automatic step;
        @(posedge clk_i);
        #1;
    endtask : step
    // bounded wait; running out ends the run as a failure
    // sel picks the strobe: 0 waits for ready, 1 for retire
    task automatic wait_hi(input bit sel, output int k);
        k = 0;
        while ((sel ? retire_o : instr_ready_o) !== 1'b1)
        begin
            step();
            k++;
            if (k > 9)
            begin
                failures++;
                results();
            end
        end
    endtask : wait_hi
    task automatic do_reset(input mito_pkg::mito_cfg_t c);
        arst_n_i = 1'b0;
        cfg_i = c;
        repeat (6) step();
        arst_n_i = 1'b1;
        step();
        step();
        chk(cfg_o, c);
        cfg_i = ~c; // later fuse changes must not reach the core
        {acc, cy, zf, pc, to_cnt} = '0;
        stk.delete();
    endtask : do_reset
    // ****************************************
    // one instruction through model and core
    // ****************************************
    task automatic run(input mito_pkg::mito_op_t op);
        mito_pkg::mito_instr_t ins;
        int opd, r, alu, skp, two, wd, ta, k;
        // keep the stack inside its depth: wrap-around is not modelled
        if (op inside {mito_pkg::OP_RET, mito_pkg::OP_INTERRUPT_EXIT} && stk.size() == 0)
            op = mito_pkg::OP_CALL;
        if (op == mito_pkg::OP_CALL && stk.size() == 4) op = mito_pkg::OP_RET;
        ins = 31'($urandom);
        ins.op = op;
        alu = op >= mito_pkg::OP_ADD && op <= mito_pkg::OP_RLC;
        ins.src_imm = ins.src_imm && alu;
        // any alu result may target the pc low byte, not only the transfer
        ins.to_pcl = ins.to_pcl && (alu || op == mito_pkg::OP_MOV_AM);
        ins.to_mem = !ins.to_pcl && (alu ? ins.to_mem : op inside {mito_pkg::OP_BSET,
            mito_pkg::OP_BCLR, mito_pkg::OP_MOV_AM});
        mem_rdata_i = 8'($urandom);
        table_data_i = 8'($urandom);
        opd = ins.src_imm ? ins.imm : mem_rdata_i;
        skp = (op == mito_pkg::OP_SKZ && opd == 0) ||
            (op == mito_pkg::OP_SKBIT && opd[ins.bit_idx]);
        case (op)
            mito_pkg::OP_ADD: r = acc + opd;
            mito_pkg::OP_SUB: r = acc - opd;
            mito_pkg::OP_AND: r = acc & opd;
            mito_pkg::OP_OR: r = acc | opd;
            mito_pkg::OP_XOR: r = acc ^ opd;
            mito_pkg::OP_CPL: r = ~opd;
            mito_pkg::OP_INC: r = opd + 1;
            mito_pkg::OP_DEC: r = opd - 1;
            mito_pkg::OP_RR: r = (opd >> 1) | (opd << 7);
            mito_pkg::OP_RL: r = (opd << 1) | (opd >> 7);
            mito_pkg::OP_RRC: r = (opd >> 1) | (cy << 7);
            default: r = (opd << 1) | cy;
        endcase
        if (op inside {mito_pkg::OP_ADD, mito_pkg::OP_SUB}) cy = r > 255 || r < 0;
        if (op == mito_pkg::OP_RRC) cy = opd & 1;
        if (op == mito_pkg::OP_RLC) cy = opd >> 7;
        r = r & 255;
        if (alu) zf = r == 0;
        wd = op == mito_pkg::OP_BSET ? opd | (1 << ins.bit_idx) : op == mito_pkg::OP_BCLR ?
            opd & ~(1 << ins.bit_idx) & 255 : op == mito_pkg::OP_MOV_AM ? acc : r;
        ta = (pc & 'hF00) | acc;
        two = ins.to_pcl || skp || op inside {mito_pkg::OP_JMP, mito_pkg::OP_CALL,
            mito_pkg::OP_RET, mito_pkg::OP_INTERRUPT_EXIT, mito_pkg::OP_TBL};
        if (op == mito_pkg::OP_CALL) stk.push_back((pc + 1) & 'hFFF);
        case (op)
            mito_pkg::OP_JMP, mito_pkg::OP_CALL: pc = ins.target;
            mito_pkg::OP_RET, mito_pkg::OP_INTERRUPT_EXIT: pc = stk.pop_back();
            default: pc = (pc + 1 + skp) & 'hFFF;
        endcase
        if (ins.to_pcl) pc = (ta & 'hF00) | wd;
        if (alu && !ins.to_mem && !ins.to_pcl) acc = r;
        if (op == mito_pkg::OP_MOV_MA) acc = opd;
        if (op == mito_pkg::OP_MOV_IA) acc = ins.imm;
        if (op == mito_pkg::OP_TBL) acc = table_data_i;
        wait_hi(0, k);
        instr_i = ins;
        instr_valid_i = 1'b1;
        step();
        instr_valid_i = 1'b0;
        chk(mem_we_o, ins.to_mem);
        if (ins.to_mem) chk(mem_wdata_o, wd);
        if (op == mito_pkg::OP_TBL) chk(tbl_addr_o, ta);
        wait_hi(1, k);
        chk(k, two ? 4 : 0);
        chk(pc_o, pc);
        chk(acc_o, acc);
        chk({carry_o, zero_o}, {cy[0], zf[0]});
        wait_hi(0, k);
        chk(k, 3);
    endtask : run
    // reset with chosen watchdog options, run a stream, judge the overflow count
    task automatic session(input logic en, osc, dual, orun, rnd, input mito_pkg::mito_op_t a, b,
        input logic exp);
        mito_pkg::mito_cfg_t c;
        int i;
        c = 20'($urandom);
        {c.wdt_en, c.wdt_from_osc, c.wdt_dual_clear} = {en, osc, dual};
        osc_run = orun;
        do_reset(c);
        for (i = 0; i < (rnd ? 300 : 30); i++)
            run(rnd ? mito_pkg::mito_op_t'($urandom_range(0, 27)) : (i % 2 ? b : a));
        chk(to_cnt > 0, exp);
        chk(cfg_o, c);
        $display("session done en=%0d osc=%0d dual=%0d", en, osc, dual);
    endtask : session
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        void'($urandom(32'h47AE));
        session(0, 0, 0, 0, 1, mito_pkg::OP_NOP, mito_pkg::OP_NOP, 0);
        session(1, 0, 0, 0, 0, mito_pkg::OP_NOP, mito_pkg::OP_NOP, 1);
        session(1, 0, 0, 0, 0, mito_pkg::OP_WDC, mito_pkg::OP_WDC, 0);
        session(1, 0, 1, 0, 0, mito_pkg::OP_WDC1, mito_pkg::OP_WDC1, 1);
        session(1, 0, 1, 0, 0, mito_pkg::OP_WDC1, mito_pkg::OP_WDC2, 0);
        session(1, 0, 1, 0, 0, mito_pkg::OP_WDC, mito_pkg::OP_WDC, 1);
        session(1, 1, 0, 1, 0, mito_pkg::OP_NOP, mito_pkg::OP_NOP, 1);
        session(1, 1, 0, 0, 0, mito_pkg::OP_NOP, mito_pkg::OP_NOP, 0);
        results();
    end
endmodule : mito_core_bench
`default_nettype wire
